// [hw/asq_pkg.sv]
package asq_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0]  ASQ_CFG_ADDR    = 8'h8c;  // sequencer configuration
  localparam logic [7:0]  ASQ_SPARE_ADDR  = 8'h8d;  // crc check scratch
  localparam int          MODE_HI         = 15;
  localparam int          MODE_LO         = 14;
  localparam int          DELAY_HI        = 10;
  localparam int          DELAY_LO        = 8;
  localparam int          OSR_HI          = 1;
  localparam int          OSR_LO          = 0;
  localparam int          SPARE_HI        = 7;
  localparam logic [15:0] CFG_RESET       = 16'h0000;
  localparam logic [7:0]  SPARE_RESET     = 8'h00;

  // ------------------------------------------------------------
  // timing, in master-clock periods (the block clock)
  // ------------------------------------------------------------
  localparam int          TW              = 13;     // wide enough for 4096
  localparam logic [12:0] DLY_C0          = 13'h0010; // 16
  localparam logic [12:0] DLY_C1          = 13'h0040; // 64
  localparam logic [12:0] DLY_C2          = 13'h0080; // 128
  localparam logic [12:0] DLY_C3          = 13'h0100; // 256
  localparam logic [12:0] DLY_C4          = 13'h0200; // 512
  localparam logic [12:0] DLY_C5          = 13'h0400; // 1024
  localparam logic [12:0] DLY_C6          = 13'h0800; // 2048
  localparam logic [12:0] DLY_C7          = 13'h1000; // 4096
  localparam logic [12:0] CONV_OSR64      = 13'h0180; // 384
  localparam logic [12:0] CONV_OSR128     = 13'h0200; // 512
  localparam logic [12:0] CONV_OSR256     = 13'h0300; // 768
  localparam logic [12:0] CONV_OSR512     = 13'h0500; // 1280

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SOFT   = 2'b00,
    MODE_DRDY   = 2'b01,
    MODE_CONT_A = 2'b10,
    MODE_CONT_B = 2'b11
  } asq_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SETTLE  = 2'b01,
    ST_CONVERT = 2'b10
  } asq_state_type;

  typedef struct packed {
    asq_mode_type mode;
    logic [2:0]   delay;
    logic [1:0]   osr;
  } asq_cfg_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } asq_req_type;

  // settle delay code to master-clock periods
  function automatic logic [12:0] delay_cycles(input logic [2:0] code);
    case (code)
      3'h0:    delay_cycles = DLY_C0;
      3'h1:    delay_cycles = DLY_C1;
      3'h2:    delay_cycles = DLY_C2;
      3'h3:    delay_cycles = DLY_C3;
      3'h4:    delay_cycles = DLY_C4;
      3'h5:    delay_cycles = DLY_C5;
      3'h6:    delay_cycles = DLY_C6;
      default: delay_cycles = DLY_C7;
    endcase
  endfunction : delay_cycles

  // oversampling code to conversion time (sinc3 x64 then sinc1 x1/2/4/8)
  function automatic logic [12:0] conv_cycles(input logic [1:0] code);
    case (code)
      2'h0:    conv_cycles = CONV_OSR64;
      2'h1:    conv_cycles = CONV_OSR128;
      2'h2:    conv_cycles = CONV_OSR256;
      default: conv_cycles = CONV_OSR512;
    endcase
  endfunction : conv_cycles

endpackage : asq_pkg

// [hw/asq_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module asq_sequencer #(
  parameter int NUM_STEPS = 4,
  parameter int CW        = 2
) (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire asq_pkg::asq_req_type reg_req,
  output var  logic [15:0]          reg_rdata,
  input  wire logic                 sequence_start_bit,
  input  wire logic                 current_adc_data_ready_n,
  input  wire logic                 aux_adc_enable,
  input  wire logic [NUM_STEPS-1:0] step_enables,
  output var  asq_pkg::asq_cfg_type seq_cfg,
  output var  logic                 sequence_busy,
  output var  logic                 conversion_start,
  output var  logic                 conversion_done,
  output var  logic [CW-1:0]        sequence_step_counter
);
  import asq_pkg::*;

  if (NUM_STEPS < 1 || NUM_STEPS > (1 << CW)) begin : g_chk
    $error("asq_sequencer: NUM_STEPS does not fit CW");
  end

  // ------------------------------------------------------------
  // step search
  // ------------------------------------------------------------
  // lowest enabled step at or above from; msb flags a hit
  function automatic logic [CW:0] find_step(input logic [NUM_STEPS-1:0] en, input int from);
    logic [CW:0] r;
    r = '0;
    for (int i = NUM_STEPS - 1; i >= 0; i--) begin
      if (en[i] && i >= from) begin
        r = {1'b1, CW'(i)};
      end
    end
    return r;
  endfunction : find_step

  asq_cfg_type   cfg_ff;
  logic [7:0]    spare_ff;
  logic [15:0]   rdata_ff;
  asq_state_type state_ff, nxt_state;
  logic [CW-1:0] step_ff, nxt_step;
  logic          busy_ff, conv_start_ff, conv_done_ff;
  logic          drdy_s1_ff, drdy_s2_ff, drdy_prev_ff;
  logic          tmr_done;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  wire         wr_cfg   = reg_req.wr && reg_req.addr == ASQ_CFG_ADDR;
  wire         wr_spare = reg_req.wr && reg_req.addr == ASQ_SPARE_ADDR;
  // reserved bits are forced to zero on every read
  wire [15:0]  cfg_word = {cfg_ff.mode, 3'h0, cfg_ff.delay, 6'h00, cfg_ff.osr};
  wire [15:0]  rd_mux   = (reg_req.addr == ASQ_CFG_ADDR)   ? cfg_word :
                          (reg_req.addr == ASQ_SPARE_ADDR) ? {8'h00, spare_ff} :
                          16'h0000;

  // writes store only writable fields; no lockout while enabled, software keeps the order
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cfg_ff   <= asq_cfg_type'(CFG_RESET[6:0]);
      spare_ff <= SPARE_RESET;
      rdata_ff <= 16'h0000;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= {asq_mode_type'(reg_req.wdata[MODE_HI:MODE_LO]),
                   reg_req.wdata[DELAY_HI:DELAY_LO], reg_req.wdata[OSR_HI:OSR_LO]};
      end
      if (wr_spare) begin
        spare_ff <= reg_req.wdata[SPARE_HI:0];
      end
      if (reg_req.rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // data-ready pin synchroniser and falling edge
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      drdy_s1_ff   <= 1'b1;
      drdy_s2_ff   <= 1'b1;
      drdy_prev_ff <= 1'b1;
    end else begin
      drdy_s1_ff   <= current_adc_data_ready_n;
      drdy_s2_ff   <= drdy_s1_ff;
      drdy_prev_ff <= drdy_s2_ff;
    end
  end

  // ------------------------------------------------------------
  // trigger decode and sequencer state machine
  // ------------------------------------------------------------
  wire          drdy_fall  = drdy_prev_ff && !drdy_s2_ff;
  wire          sw_go      = aux_adc_enable && sequence_start_bit;
  // edge counts only when idle, so it never aborts a running pass
  wire          drdy_go    = aux_adc_enable && cfg_ff.mode == MODE_DRDY &&
                             state_ff == ST_IDLE && drdy_fall;
  wire          go         = sw_go || drdy_go;
  wire          continuous = cfg_ff.mode[1];
  wire [CW:0]   first_hit  = find_step(step_enables, 0);
  wire [CW:0]   next_hit   = find_step(step_enables, int'(step_ff) + 1);
  logic         load_delay, load_conv;
  wire          tmr_load   = load_delay || load_conv;
  wire [TW-1:0] tmr_val    = load_conv ? conv_cycles(cfg_ff.osr) : delay_cycles(cfg_ff.delay);

  always_comb begin
    nxt_state  = state_ff;
    nxt_step   = step_ff;
    load_delay = 1'b0;
    load_conv  = 1'b0;
    if (!aux_adc_enable) begin
      nxt_state = ST_IDLE;
      nxt_step  = '0;
    end else if (go) begin
      // abort whatever runs and restart from the first enabled step
      nxt_state  = first_hit[CW] ? ST_SETTLE : ST_IDLE;
      nxt_step   = first_hit[CW-1:0];
      load_delay = first_hit[CW];
    end else begin
      case (state_ff)
        ST_SETTLE: begin
          if (tmr_done) begin
            nxt_state = ST_CONVERT;
            load_conv = 1'b1;
          end
        end
        ST_CONVERT: begin
          if (tmr_done && next_hit[CW]) begin
            nxt_state  = ST_SETTLE;
            nxt_step   = next_hit[CW-1:0];
            load_delay = 1'b1;
          end else if (tmr_done && continuous && first_hit[CW]) begin
            nxt_state  = ST_SETTLE;
            nxt_step   = first_hit[CW-1:0];
            load_delay = 1'b1;
          end else if (tmr_done) begin
            nxt_state = ST_IDLE;
          end
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_ff      <= ST_IDLE;
      step_ff       <= '0;
      busy_ff       <= 1'b0;
      conv_start_ff <= 1'b0;
      conv_done_ff  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      step_ff       <= nxt_step;
      busy_ff       <= nxt_state != ST_IDLE;
      conv_start_ff <= load_conv;
      conv_done_ff  <= aux_adc_enable && !go && state_ff == ST_CONVERT && tmr_done;
    end
  end

  // settle and conversion timing share one master-clock counter
  asq_step_timer #(
    .W (TW)
  ) u_timer (
    .clock    (clock),
    .nrst     (nrst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done_ff  (tmr_done)
  );

  assign reg_rdata             = rdata_ff;
  assign seq_cfg               = cfg_ff;
  assign sequence_busy         = busy_ff;
  assign conversion_start      = conv_start_ff;
  assign conversion_done       = conv_done_ff;
  assign sequence_step_counter = step_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // edges since the last timer load; it equals the loaded count in the cycle that done is seen
  logic [TW:0] phase_len_ff;
  always_ff @(posedge clock) begin
    if (!nrst || tmr_load) begin
      phase_len_ff <= '0;
    end else begin
      phase_len_ff <= phase_len_ff + 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_cfg_field_store: assert property (wr_cfg |=> cfg_ff.delay == $past(reg_req.wdata[DELAY_HI:DELAY_LO])
    && cfg_ff.mode == $past(reg_req.wdata[MODE_HI:MODE_LO])) else $error("cfg field not stored");
  a_reserved_read_zero: assert property (reg_req.rd && reg_req.addr == ASQ_CFG_ADDR
    |=> rdata_ff[13:11] == 3'h0 && rdata_ff[7:2] == 6'h00) else $error("reserved bits read nonzero");
  a_spare_high_zero: assert property (reg_req.rd && reg_req.addr == ASQ_SPARE_ADDR
    |=> rdata_ff[15:8] == 8'h00) else $error("spare high byte read nonzero");
  a_spare_write_back: assert property (wr_spare ##1 (reg_req.rd && reg_req.addr == ASQ_SPARE_ADDR && !reg_req.wr)
    |=> rdata_ff == {8'h00, $past(reg_req.wdata[7:0], 2)}) else $error("spare readback wrong");
  a_start_restart: assert property (sw_go && first_hit[CW] |=> state_ff == ST_SETTLE
    && step_ff == $past(first_hit[CW-1:0])) else $error("start did not restart");
  a_single_stop: assert property (aux_adc_enable && !go && state_ff == ST_CONVERT && tmr_done && !next_hit[CW]
    && !continuous |=> state_ff == ST_IDLE) else $error("single pass did not stop");
  a_drdy_start: assert property (aux_adc_enable && cfg_ff.mode == MODE_DRDY && state_ff == ST_IDLE
    && drdy_fall && first_hit[CW] |=> state_ff == ST_SETTLE ##1 sequence_busy) else $error("drdy edge missed");
  a_drdy_ignored: assert property (aux_adc_enable && state_ff != ST_IDLE && !sequence_start_bit && !tmr_done
    |=> $stable(step_ff) && state_ff == $past(state_ff)) else $error("busy sequence disturbed");
  a_cont_repeat: assert property (aux_adc_enable && !go && state_ff == ST_CONVERT && tmr_done && !next_hit[CW]
    && continuous && first_hit[CW] |=> state_ff == ST_SETTLE && step_ff == $past(first_hit[CW-1:0]))
    else $error("continuous mode did not repeat");
  a_settle_time: assert property (load_conv && state_ff == ST_SETTLE
    |-> phase_len_ff == {1'b0, delay_cycles(cfg_ff.delay)}) else $error("settle length wrong");
  a_conv_time: assert property (aux_adc_enable && !go && state_ff == ST_CONVERT && tmr_done
    |-> phase_len_ff == {1'b0, conv_cycles(cfg_ff.osr)}) else $error("conversion length wrong");
  a_step_enabled: assert property (state_ff != ST_IDLE |-> step_enables[step_ff])
    else $error("disabled step visited");

  c_drdy_pass: cover property (drdy_go ##1 state_ff == ST_SETTLE);
  c_cont_wrap: cover property (continuous && state_ff == ST_CONVERT && tmr_done && !next_hit[CW]);
  c_abort: cover property (sw_go && state_ff == ST_CONVERT);

endmodule : asq_sequencer
`default_nettype wire

// [hw/asq_step_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module asq_step_timer #(
  parameter int W = 13
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output var  logic         done_ff
);
  import asq_pkg::*;

  logic [W-1:0] cnt_ff;
  logic         run_ff;

  if (W < 2) begin : g_chk
    $error("asq_step_timer: W too small");
  end

  // ------------------------------------------------------------
  // down counter; done pulses load_val edges after the load edge
  // ------------------------------------------------------------
  // a load always wins so an abort restarts the count cleanly
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_ff  <= '0;
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else if (load) begin
      cnt_ff  <= load_val - 1'b1;
      run_ff  <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= (run_ff && cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
      run_ff  <= run_ff && cnt_ff != '0;
      done_ff <= run_ff && cnt_ff == '0;
    end
  end

endmodule : asq_step_timer
`default_nettype wire

// [tb/asq_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module asq_host_model (
  input  wire logic                 clock,
  output var  asq_pkg::asq_req_type reg_req,
  output var  logic                 sequence_start_bit
);
  import asq_pkg::*;

  // ----------------------------------------
  // idle bus
  // ----------------------------------------
  initial begin
    reg_req            = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 16'h0000};
    sequence_start_bit = 1'b0;
  end

  // ----------------------------------------
  // transfers, entered just after an edge
  // ----------------------------------------
  // request held to the taking edge; afterwards addr and data show the
  // inverse so a stale word never passes for a live one; hold_bus leaves
  // the bus up so a back-to-back transfer assigns it only once per step
  task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wdata, input logic hold_bus);
    reg_req = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(posedge clock);
    #1;
    if (!hold_bus) begin
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
    end
  endtask : access

  // software write of the start bit, one cycle wide
  task automatic pulse_start();
    sequence_start_bit = 1'b1;
    @(posedge clock);
    #1;
    sequence_start_bit = 1'b0;
  endtask : pulse_start
endmodule : asq_host_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import asq_pkg::*;
  logic        clock, nrst, drdy_n, enable, start, busy, cstart, cdone;
  logic [3:0]  step_en;
  logic [1:0]  step;
  logic [15:0] rdata;
  asq_req_type req;
  asq_cfg_type cfg;
  int          num_errors  = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  int          dly[8]      = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
  int          conv[4]     = '{384, 512, 768, 1280};

  asq_host_model asq_host_model_i (.clock(clock), .reg_req(req), .sequence_start_bit(start));
  asq_sequencer #(.NUM_STEPS(4), .CW(2)) asq_sequencer_i (
    .clock(clock), .nrst(nrst), .reg_req(req), .reg_rdata(rdata), .sequence_start_bit(start),
    .current_adc_data_ready_n(drdy_n), .aux_adc_enable(enable), .step_enables(step_en),
    .seq_cfg(cfg), .sequence_busy(busy), .conversion_start(cstart), .conversion_done(cdone),
    .sequence_step_counter(step));

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // the delay sweep dominates at about 14k cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("unexpected at %0t: run timed out", $time);
      conclude();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    asq_host_model_i.access(1'b0, a, 16'h0000, 1'b0);
    d = rdata;
    tick();
  endtask : rd
  // config only changes with the converter off
  task automatic cfg_write(input logic [1:0] m, input logic [2:0] d, input logic [1:0] o);
    enable = 1'b0;
    asq_host_model_i.access(1'b1, 8'h8c, {m, 3'h0, d, 6'h00, o}, 1'b0);
    tick();
    check(16'(cfg), {9'h000, m, d, o}, "cfg fields");
    enable = 1'b1;
  endtask : cfg_write
  // sel 0 conversion start, 1 conversion done, 2 idle; n counts cycles
  task automatic wait_for(input int sel, output int n);
    n = 0;
    do begin
      tick();
      n++;
    end while (n < 6000 && !(sel == 0 ? cstart === 1'b1 : sel == 1 ? cdone === 1'b1 : busy === 1'b0));
  endtask : wait_for

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [15:0] d;
    rd(8'h8c, d); check(d, 16'h0000, "cfg reset");
    rd(8'h8d, d); check(d, 16'h0000, "spare reset");
    asq_host_model_i.access(1'b1, 8'h8c, 16'hffff, 1'b1);
    rd(8'h8c, d); check(d, 16'hc703, "cfg reserved");
    asq_host_model_i.access(1'b1, 8'h8d, 16'hffff, 1'b1);
    rd(8'h8d, d); check(d, 16'h00ff, "spare bits");
    rd(8'h8e, d); check(d, 16'h0000, "unmapped read");
    check(16'(cfg), 16'h007f, "spare no effect");
    $display("test regs done");
  endtask : t_regs

  // every delay code and oversampling code, one step, single shot
  task automatic t_timing();
    int n;
    int m;
    step_en = 4'b0001;
    for (int c = 0; c < 8; c++) begin
      cfg_write(2'b00, 3'(c), 2'(c));
      asq_host_model_i.pulse_start();
      check(16'(busy), 16'h0001, "busy after start");
      wait_for(0, n);
      check(16'(n + 1), 16'(dly[c] + 2), "settle time");
      wait_for(1, m);
      check(16'(m), 16'(conv[c % 4] + 1), "conversion time");
      check(16'(busy), 16'h0000, "single pass stops");
    end
    $display("test timing done");
  endtask : t_timing

  // edge trigger, skipped steps, and an edge ignored mid-sequence
  task automatic t_drdy();
    int n;
    cfg_write(2'b01, 3'h0, 2'h0);
    step_en = 4'b1010;
    drdy_n  = 1'b0;
    wait_for(0, n);
    check(16'(step), 16'h0001, "first enabled step");
    drdy_n = 1'b1;
    tick();
    tick();
    drdy_n = 1'b0;
    wait_for(1, n);
    check(16'(n), 16'(conv[0] - 1), "edge while busy ignored");
    check(16'(step), 16'h0003, "step 2 skipped");
    wait_for(2, n);
    repeat (30) tick();
    check(16'(busy), 16'h0000, "one pass per edge");
    drdy_n = 1'b1;
    $display("test drdy done");
  endtask : t_drdy

  // both continuous codes, abort mid-sequence, wrap, disable
  task automatic t_cont();
    int n;
    step_en = 4'b0011;
    for (int mo = 2; mo < 4; mo++) begin
      cfg_write(2'(mo), 3'h0, 2'h0);
      asq_host_model_i.pulse_start();
      wait_for(1, n);
      repeat (20) tick();
      asq_host_model_i.pulse_start();
      check(16'(step), 16'h0000, "abort to first step");
      wait_for(0, n);
      check(16'(n + 1), 16'd18, "fresh settle");
      wait_for(1, n);
      wait_for(1, n);
      check(16'({busy, step}), 16'h0004, "wrap to first");
      enable = 1'b0;
      tick();
      tick();
      check(16'({busy, step}), 16'h0000, "disable clears");
    end
    $display("test cont done");
  endtask : t_cont

  // ----------------------------------------
  // main sequence and verdict
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    nrst    = 1'b0;
    drdy_n  = 1'b1;
    enable  = 1'b0;
    step_en = 4'h0;
    repeat (5) @(posedge clock);
    #1;
    nrst = 1'b1;
    t_regs();
    t_timing();
    t_drdy();
    t_cont();
    conclude();
  end
endmodule : testbench
`default_nettype wire
